/* File: rtl/plfb_pkg.sv */
// Shared constants and types for the PCI link FIFO bridge
package plfb_pkg;

  // FIFO geometry
  localparam int unsigned FIFO_W     = 8;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned LVL_W      = 4;
  localparam logic [LVL_W-1:0] LVL_FULL = 4'h8;

  // Register byte offsets inside the I/O window
  localparam int unsigned IO_ADDR_W = 5;
  localparam logic [4:0] OFS_RX_BYTE  = 5'h00;
  localparam logic [4:0] OFS_TX_BYTE  = 5'h01;
  localparam logic [4:0] OFS_RX_STAT  = 5'h02;
  localparam logic [4:0] OFS_TX_STAT  = 5'h03;
  localparam logic [4:0] OFS_RX_WIDE  = 5'h08;
  localparam logic [4:0] OFS_TX_WIDE  = 5'h0c;
  localparam logic [4:0] OFS_SLOT_RST = 5'h10;
  localparam logic [4:0] OFS_SLOT_HLT = 5'h11;
  localparam logic [4:0] OFS_RX_LVL   = 5'h18;
  localparam logic [4:0] OFS_TX_LVL   = 5'h1c;
  localparam int unsigned CTL_BIT     = 0;
  localparam logic [1:0] LANE_LAST    = 2'h3;

  // Configuration space dword indices and fixed bits
  localparam logic [5:0]  CFG_IDX_ID   = 6'h00;
  localparam logic [5:0]  CFG_IDX_CMD  = 6'h01;
  localparam logic [5:0]  CFG_IDX_BAR0 = 6'h04;
  localparam logic [31:0] BAR0_IO_FLAG = 32'h0000_0001;
  localparam logic [15:0] VENDOR_ID    = 16'h5a5a; // Arbitrary value
  localparam logic [15:0] DEVICE_ID    = 16'h0c3e; // Arbitrary value

  // Link bit rates
  localparam logic [4:0] RATE_FAST_MHZ = 5'd20;
  localparam logic [4:0] RATE_SLOW_MHZ = 5'd10;

  typedef struct packed {
    logic        we;
    logic [31:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } plfb_io_req_s;

  typedef struct packed {
    logic reset;
    logic halt;
  } plfb_slot_ctl_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LANE = 3'b010,
    ST_DONE = 3'b100
  } plfb_state_e;

endpackage

/* File: rtl/plfb_bridge.sv */
// PCI link FIFO bridge: byte FIFO and register block top
`timescale 1ns/1ns

// Byte FIFO with flush, registered flags
module plfb_fifo #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  input  wire logic                       flush,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [W-1:0]               in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [W-1:0]                    out_data,
  output logic [$clog2(DEPTH):0]          level
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic [AW:0]   cnt_d;
  logic          push;
  logic          pop;

  // Handshakes and next count
  assign push  = in_valid && in_ready;
  assign pop   = out_valid && out_ready;
  assign cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign out_data = mem_q[rd_q];
  assign level    = cnt_q;

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers, count and flags
  always_ff @(posedge clk) begin
    if (sys_rst || flush) begin
      wr_q      <= '0;
      rd_q      <= '0;
      cnt_q     <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q     <= cnt_d;
      in_ready  <= cnt_d != (AW+1)'(DEPTH);
      out_valid <= cnt_d != '0;
    end
  end
endmodule // plfb_fifo

module plfb_bridge (
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    io_valid,
  input  wire plfb_pkg::plfb_io_req_s  io_req,
  output logic                         io_ack,
  output logic [31:0]                  io_rdata,
  input  wire logic                    cfg_valid,
  input  wire logic                    cfg_we,
  input  wire logic [5:0]              cfg_idx,
  input  wire logic [31:0]             cfg_wdata,
  output logic                         cfg_ack,
  output logic [31:0]                  cfg_rdata,
  input  wire logic                    link_rx_valid,
  output logic                         link_rx_ready,
  input  wire logic [7:0]              link_rx_data,
  output logic                         link_tx_valid,
  input  wire logic                    link_tx_ready,
  output logic [7:0]                   link_tx_data,
  output logic                         link_rst,
  output logic [4:0]                   link_rate_mhz,
  input  wire logic                    link_rate_switch,
  input  wire logic                    first_slot_control_switch,
  input  wire logic                    slave_slots_control_switch,
  input  wire logic                    first_slot_error,
  input  wire plfb_pkg::plfb_slot_ctl_s up_ctl,
  output logic                         up_error,
  input  wire plfb_pkg::plfb_slot_ctl_s sub_ctl,
  output plfb_pkg::plfb_slot_ctl_s     first_slot,
  output plfb_pkg::plfb_slot_ctl_s     slave_slots
);

  // Pick one byte lane out of a word
  function automatic logic [7:0] lane_byte(input logic [31:0] w, input logic [1:0] l);
    lane_byte = w[8*l +: 8];
  endfunction

  plfb_pkg::plfb_state_e    state_q;
  plfb_pkg::plfb_io_req_s   req_q;
  logic                     hit_q;
  logic [1:0]               lane_q;
  logic [4:0]               off;
  logic [2:0]               dw;
  logic                     lane_en;
  logic                     rx_sel;
  logic                     tx_sel;
  logic                     rx_pop;
  logic                     tx_push;
  logic                     lane_stall;
  logic [7:0]               rd_byte;
  logic [7:0]               wr_byte;
  logic [plfb_pkg::LVL_W-1:0] rx_level;
  logic [plfb_pkg::LVL_W-1:0] tx_level;
  logic [plfb_pkg::LVL_W-1:0] rx_snap_q;
  logic [plfb_pkg::LVL_W-1:0] tx_free_snap_q;
  logic                     rx_out_valid;
  logic [7:0]               rx_out_data;
  logic                     tx_in_ready;
  logic                     slot_rst_q;
  logic                     halt_q;
  logic                     io_en_q;
  logic [31:0]              bar_q;
  logic [7:0]               sync_a_q;
  logic [7:0]               sync_b_q;
  logic                     rate_s;
  logic                     fs_sw_s;
  logic                     ss_sw_s;
  logic                     err_s;
  plfb_pkg::plfb_slot_ctl_s up_s;
  plfb_pkg::plfb_slot_ctl_s sub_s;
  plfb_pkg::plfb_slot_ctl_s first_src;
  logic                     io_hit;

  // Pin synchroniser, two stages
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync_a_q <= 8'h00;
      sync_b_q <= 8'h00;
    end else begin
      sync_a_q <= {link_rate_switch, first_slot_control_switch, slave_slots_control_switch,
                   first_slot_error, up_ctl, sub_ctl};
      sync_b_q <= sync_a_q;
    end
  end
  assign {rate_s, fs_sw_s, ss_sw_s, err_s, up_s, sub_s} = sync_b_q;

  // Both FIFOs shared by all ports; flushed in link reset
  plfb_fifo #(.W(plfb_pkg::FIFO_W), .DEPTH(plfb_pkg::FIFO_DEPTH)) u_rx_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .flush     (slot_rst_q),
    .in_valid  (link_rx_valid),
    .in_ready  (link_rx_ready),
    .in_data   (link_rx_data),
    .out_valid (rx_out_valid),
    .out_ready (rx_pop),
    .out_data  (rx_out_data),
    .level     (rx_level)
  );

  plfb_fifo #(.W(plfb_pkg::FIFO_W), .DEPTH(plfb_pkg::FIFO_DEPTH)) u_tx_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .flush     (slot_rst_q),
    .in_valid  (tx_push),
    .in_ready  (tx_in_ready),
    .in_data   (wr_byte),
    .out_valid (link_tx_valid),
    .out_ready (link_tx_ready),
    .out_data  (link_tx_data),
    .level     (tx_level)
  );

  // Window decode against base address register 0
  assign io_hit = io_en_q &&
                  io_req.addr[31:plfb_pkg::IO_ADDR_W] == bar_q[31:plfb_pkg::IO_ADDR_W];

  // Current lane decode
  assign dw      = req_q.addr[4:2];
  assign off     = {dw, lane_q};
  assign lane_en = (state_q == plfb_pkg::ST_LANE) && hit_q && req_q.be[lane_q];
  assign wr_byte = lane_byte(req_q.wdata, lane_q);
  // Receive lanes: byte port and wide port
  assign rx_sel  = !req_q.we && (off == plfb_pkg::OFS_RX_BYTE ||
                                 dw == plfb_pkg::OFS_RX_WIDE[4:2]);
  // Transmit lanes: byte port and wide port
  assign tx_sel  = req_q.we && (off == plfb_pkg::OFS_TX_BYTE ||
                                dw == plfb_pkg::OFS_TX_WIDE[4:2]);
  assign rx_pop     = lane_en && rx_sel && rx_out_valid;
  assign tx_push    = lane_en && tx_sel && tx_in_ready;
  assign lane_stall = lane_en && tx_sel && !tx_in_ready;

  // Read data of the current lane
  always_comb begin
    rd_byte = 8'h00;
    if (lane_en && !req_q.we) begin
      if (rx_sel) begin
        rd_byte = rx_out_valid ? rx_out_data : 8'h00;
      end else if (off == plfb_pkg::OFS_RX_STAT) begin
        rd_byte = {7'h00, rx_out_valid};
      end else if (off == plfb_pkg::OFS_TX_STAT) begin
        rd_byte = {7'h00, tx_in_ready};
      end else if (off == plfb_pkg::OFS_SLOT_RST) begin
        rd_byte = {7'h00, err_s};
      end else if (off == plfb_pkg::OFS_SLOT_HLT) begin
        rd_byte = {7'h00, halt_q};
      end else if (dw == plfb_pkg::OFS_RX_LVL[4:2]) begin
        rd_byte = lane_byte({28'h0000000, rx_snap_q}, lane_q);
      end else if (dw == plfb_pkg::OFS_TX_LVL[4:2]) begin
        rd_byte = lane_byte({28'h0000000, tx_free_snap_q}, lane_q);
      end
    end
  end

  // Access sequencer: one lane per cycle, stalls on a full transmit FIFO
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q        <= plfb_pkg::ST_IDLE;
      req_q          <= '0;
      hit_q          <= 1'b0;
      lane_q         <= 2'h0;
      rx_snap_q      <= '0;
      tx_free_snap_q <= '0;
    end else begin
      unique case (state_q)
        plfb_pkg::ST_IDLE: begin
          if (io_valid && !io_ack) begin
            req_q          <= io_req;
            hit_q          <= io_hit;
            lane_q         <= 2'h0;
            // Levels frozen for the whole access
            rx_snap_q      <= rx_level;
            tx_free_snap_q <= plfb_pkg::LVL_FULL - tx_level;
            state_q        <= plfb_pkg::ST_LANE;
          end
        end
        plfb_pkg::ST_LANE: begin
          if (!lane_stall) begin
            lane_q <= lane_q + 2'h1;
            if (lane_q == plfb_pkg::LANE_LAST) begin
              state_q <= plfb_pkg::ST_DONE;
            end
          end
        end
        plfb_pkg::ST_DONE: begin
          state_q <= plfb_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Read data assembly and acknowledge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      io_rdata <= 32'h0000_0000;
      io_ack   <= 1'b0;
    end else begin
      io_ack <= state_q == plfb_pkg::ST_DONE;
      if (state_q == plfb_pkg::ST_IDLE && io_valid && !io_ack) begin
        io_rdata <= 32'h0000_0000;
      end else if (state_q == plfb_pkg::ST_LANE && !lane_stall) begin
        io_rdata[8*lane_q +: 8] <= rd_byte;
      end
    end
  end

  // Slot control bits
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      slot_rst_q <= 1'b0;
      halt_q     <= 1'b0;
    end else if (lane_en && req_q.we) begin
      if (off == plfb_pkg::OFS_SLOT_RST) begin
        slot_rst_q <= wr_byte[plfb_pkg::CTL_BIT];
      end
      if (off == plfb_pkg::OFS_SLOT_HLT) begin
        halt_q <= wr_byte[plfb_pkg::CTL_BIT];
      end
    end
  end

  always_comb begin
    first_src.reset = fs_sw_s ? up_s.reset : slot_rst_q;
    first_src.halt  = fs_sw_s ? up_s.halt  : halt_q;
  end

  // Slot, link and rate outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      first_slot    <= '0;
      slave_slots   <= '0;
      up_error      <= 1'b0;
      link_rst      <= 1'b0;
      link_rate_mhz <= plfb_pkg::RATE_FAST_MHZ;
    end else begin
      first_slot <= first_src;
      up_error   <= fs_sw_s && err_s;
      // Slave slots follow first slot or its subsystem
      slave_slots <= ss_sw_s ? first_src : sub_s;
      link_rst    <= slot_rst_q;
      link_rate_mhz <= rate_s ? plfb_pkg::RATE_SLOW_MHZ : plfb_pkg::RATE_FAST_MHZ;
    end
  end

  // Configuration space
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_ack   <= 1'b0;
      cfg_rdata <= 32'h0000_0000;
      io_en_q   <= 1'b0;
      bar_q     <= plfb_pkg::BAR0_IO_FLAG;
    end else begin
      cfg_ack <= cfg_valid && !cfg_ack;
      if (cfg_valid && !cfg_ack) begin
        cfg_rdata <= 32'h0000_0000;
        if (cfg_we) begin
          if (cfg_idx == plfb_pkg::CFG_IDX_CMD) begin
            io_en_q <= cfg_wdata[plfb_pkg::CTL_BIT];
          end
          if (cfg_idx == plfb_pkg::CFG_IDX_BAR0) begin
            bar_q <= {cfg_wdata[31:plfb_pkg::IO_ADDR_W], plfb_pkg::BAR0_IO_FLAG[4:0]};
          end
        end else if (cfg_idx == plfb_pkg::CFG_IDX_ID) begin
          cfg_rdata <= {plfb_pkg::DEVICE_ID, plfb_pkg::VENDOR_ID};
        end else if (cfg_idx == plfb_pkg::CFG_IDX_CMD) begin
          cfg_rdata <= {31'h0000_0000, io_en_q};
        end else if (cfg_idx == plfb_pkg::CFG_IDX_BAR0) begin
          cfg_rdata <= bar_q;
        end
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_rx_pop;
    rx_pop && !(link_rx_valid && link_rx_ready) |=> rx_level == $past(rx_level) - 4'h1;
  endproperty
  a_rx_pop: assert property (p_rx_pop) else $error("rx pop did not drop level");

  property p_tx_push;
    tx_push && !(link_tx_valid && link_tx_ready) |=> tx_level == $past(tx_level) + 4'h1;
  endproperty
  a_tx_push: assert property (p_tx_push) else $error("tx push did not raise level");

  property p_rx_lane;
    rx_pop |=> io_rdata[8*$past(lane_q) +: 8] == $past(rx_out_data);
  endproperty
  a_rx_lane: assert property (p_rx_lane) else $error("rx byte in wrong lane");

  property p_rx_stat;
    lane_en && !req_q.we && off == plfb_pkg::OFS_RX_STAT |=> io_rdata[16] == $past(rx_out_valid);
  endproperty
  a_rx_stat: assert property (p_rx_stat) else $error("rx status wrong");

  property p_tx_stat;
    lane_en && !req_q.we && off == plfb_pkg::OFS_TX_STAT |=> io_rdata[24] == $past(tx_in_ready);
  endproperty
  a_tx_stat: assert property (p_tx_stat) else $error("tx status wrong");

  property p_tx_free;
    state_q == plfb_pkg::ST_DONE && !req_q.we && hit_q && req_q.be[0] &&
    dw == plfb_pkg::OFS_TX_LVL[4:2] |=> io_ack && io_rdata[7:0] == {4'h0, tx_free_snap_q};
  endproperty
  a_tx_free: assert property (p_tx_free) else $error("tx free level wrong");

  property p_snap;
    state_q == plfb_pkg::ST_LANE |=> $stable(rx_snap_q) && $stable(tx_free_snap_q);
  endproperty
  a_snap: assert property (p_snap) else $error("level snapshot moved");

  property p_link_rst;
    slot_rst_q |=> link_rst ##0 rx_level == 4'h0 ##0 tx_level == 4'h0;
  endproperty
  a_link_rst: assert property (p_link_rst) else $error("link reset not applied");

  property p_rate;
    ##1 1'b1 |-> link_rate_mhz ==
      ($past(rate_s) ? plfb_pkg::RATE_SLOW_MHZ : plfb_pkg::RATE_FAST_MHZ);
  endproperty
  a_rate: assert property (p_rate) else $error("link rate wrong");

  property p_first_host;
    !fs_sw_s ##1 !fs_sw_s |-> first_slot.reset == $past(slot_rst_q) &&
                            first_slot.halt == $past(halt_q);
  endproperty
  a_first_host: assert property (p_first_host) else $error("first slot source wrong");

  property p_ack_bound;
    state_q == plfb_pkg::ST_IDLE && io_valid && !io_ack && !io_req.we |-> ##6 io_ack;
  endproperty
  a_ack_bound: assert property (p_ack_bound) else $error("read ack late");

  c_wide_read: cover property (state_q == plfb_pkg::ST_DONE && !req_q.we &&
                               req_q.be == 4'hf && dw == plfb_pkg::OFS_RX_WIDE[4:2]);
  c_tx_stall:  cover property (lane_stall [*2]);
  c_slot_rst:  cover property ($rose(link_rst));

endmodule // plfb_bridge

/* File: sim/plfb_link_model.sv */
// Link adapter model: byte source into the bridge and byte sink with stall
`timescale 1ns/1ns
module plfb_link_model (
  input  wire logic       clk,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic [7:0]      rx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_data,
  input  wire logic       stall
);
  logic [7:0] sendq[$];
  logic [7:0] gotq[$];

  // Quiet outputs at time zero
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b0;
  end

  // Handshakes complete at the rising edge
  always @(posedge clk) begin
    if (rx_valid && rx_ready) void'(sendq.pop_front());
    if (tx_valid && tx_ready) gotq.push_back(tx_data);
  end

  // Outputs move at the falling edge; idle data toggles
  always @(negedge clk) begin
    rx_valid = sendq.size() != 0;
    rx_data  = rx_valid ? sendq[0] : ~rx_data;
    tx_ready = !stall;
  end
endmodule // plfb_link_model

/* File: sim/pci_link_fifo_bridge_tb.sv */
// Self-checking bench for the PCI link FIFO bridge
`timescale 1ns/1ns
module pci_link_fifo_bridge_tb;
  localparam logic [31:0] BASE = 32'h0000_0200;
  logic                     clk, sys_rst, io_valid, io_ack, cfg_valid, cfg_we, cfg_ack;
  plfb_pkg::plfb_io_req_s   io_req;
  logic [31:0]              io_rdata, cfg_wdata, cfg_rdata, rv, w;
  logic [5:0]               cfg_idx;
  logic                     link_rx_valid, link_rx_ready, link_tx_valid, link_tx_ready;
  logic [7:0]               link_rx_data, link_tx_data, lf;
  logic                     link_rst, link_rate_switch, first_slot_control_switch;
  logic                     slave_slots_control_switch, first_slot_error, up_error, stall;
  logic [4:0]               link_rate_mhz;
  plfb_pkg::plfb_slot_ctl_s up_ctl, sub_ctl, first_slot, slave_slots;
  logic [7:0]               rq[$];
  logic [7:0]               tq[$];
  int                       failures, compares, i;

  plfb_bridge dut_u (.clk(clk), .sys_rst(sys_rst), .io_valid(io_valid), .io_req(io_req),
    .io_ack(io_ack), .io_rdata(io_rdata), .cfg_valid(cfg_valid), .cfg_we(cfg_we),
    .cfg_idx(cfg_idx), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
    .link_rx_valid(link_rx_valid), .link_rx_ready(link_rx_ready),
    .link_rx_data(link_rx_data), .link_tx_valid(link_tx_valid),
    .link_tx_ready(link_tx_ready), .link_tx_data(link_tx_data), .link_rst(link_rst),
    .link_rate_mhz(link_rate_mhz), .link_rate_switch(link_rate_switch),
    .first_slot_control_switch(first_slot_control_switch),
    .slave_slots_control_switch(slave_slots_control_switch),
    .first_slot_error(first_slot_error), .up_ctl(up_ctl), .up_error(up_error),
    .sub_ctl(sub_ctl), .first_slot(first_slot), .slave_slots(slave_slots));

  plfb_link_model lm_u (.clk(clk), .rx_valid(link_rx_valid), .rx_ready(link_rx_ready),
    .rx_data(link_rx_data), .tx_valid(link_tx_valid), .tx_ready(link_tx_ready),
    .tx_data(link_tx_data), .stall(stall));

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Next pseudo-random byte
  function automatic logic [7:0] nx(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Take n bytes from the expected receive queue, low lane first
  function automatic logic [31:0] pop(input int n);
    logic [31:0] v;
    v = 32'h0;
    for (int k = 0; k < n; k++) if (rq.size() > 0) v[8*k+:8] = rq.pop_front();
    return v;
  endfunction

  task automatic give_verdict();
    if (failures == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One I/O transfer, held until acknowledged
  task automatic io(input logic we, input logic [31:0] ofs, input logic [3:0] be,
                    input logic [31:0] wd);
    int n;
    io_req = '{we, BASE + ofs, be, wd};
    io_valid = 1'b1;
    for (n = 0; n < 100 && io_ack !== 1'b1; n++) @(negedge clk);
    rv = io_rdata;
    io_valid = 1'b0;
    if (n == 100) begin
      failures++;
      give_verdict();
    end
    @(negedge clk);
  endtask

  // Transmit write that also records the expected byte order
  task automatic put(input logic [31:0] ofs, input logic [3:0] be, input logic [31:0] wd);
    io(1'b1, ofs, be, wd);
    for (int k = 0; k < 4; k++) if (be[k]) tq.push_back(wd[8*k+:8]);
  endtask

  // One configuration transfer
  task automatic cfg(input logic we, input logic [5:0] idx, input logic [31:0] wd);
    int n;
    cfg_we = we;
    cfg_idx = idx;
    cfg_wdata = wd;
    cfg_valid = 1'b1;
    for (n = 0; n < 100 && cfg_ack !== 1'b1; n++) @(negedge clk);
    rv = cfg_rdata;
    cfg_valid = 1'b0;
    if (n == 100) begin
      failures++;
      give_verdict();
    end
    @(negedge clk);
  endtask

  task automatic rx_send(input int n);
    for (int k = 0; k < n; k++) begin
      lf = nx(lf);
      rq.push_back(lf);
      lm_u.sendq.push_back(lf);
    end
  endtask

  // Main sequence
  initial begin
    failures = 0;
    compares = 0;
    lf = 8'h3b;
    {sys_rst, io_valid, cfg_valid, cfg_we, stall} = 5'h10;
    io_req = '0;
    cfg_idx = 6'h00;
    cfg_wdata = 32'h0;
    {link_rate_switch, first_slot_control_switch, slave_slots_control_switch} = 3'h0;
    first_slot_error = 1'b0;
    up_ctl = 2'h0;
    sub_ctl = 2'h0;
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    cfg(1'b0, plfb_pkg::CFG_IDX_ID, 32'h0);
    chk("ident", rv, {plfb_pkg::DEVICE_ID, plfb_pkg::VENDOR_ID});
    cfg(1'b1, plfb_pkg::CFG_IDX_BAR0, BASE);
    cfg(1'b1, plfb_pkg::CFG_IDX_CMD, 32'h1);
    chk("rate", link_rate_mhz, plfb_pkg::RATE_FAST_MHZ);
    rx_send(7);
    // Level read before any wide read
    for (i = 0; i < 20; i++) begin
      io(1'b0, plfb_pkg::OFS_RX_LVL, 4'h3, 32'h0);
      if (rv[15:0] == 16'h7) break;
    end
    chk("rx_level", rv[15:0], 32'h7);
    io(1'b0, plfb_pkg::OFS_RX_STAT, 4'h4, 32'h0);
    chk("rx_status", rv[16], 32'h1);
    io(1'b0, plfb_pkg::OFS_RX_WIDE, 4'hf, 32'h0);
    chk("rx_wide32", rv, pop(4));
    io(1'b0, plfb_pkg::OFS_RX_BYTE, 4'h1, 32'h0);
    chk("rx_byte", rv[7:0], pop(1));
    io(1'b0, plfb_pkg::OFS_RX_WIDE, 4'h3, 32'h0);
    chk("rx_wide16", rv[15:0], pop(2));
    io(1'b0, plfb_pkg::OFS_RX_STAT, 4'h4, 32'h0);
    chk("rx_status", rv[16], 32'h0);
    io(1'b0, plfb_pkg::OFS_RX_LVL, 4'h3, 32'h0);
    chk("rx_level", rv[15:0], 32'h0);
    rx_send(1);
    io(1'b0, 32'h20, 4'h1, 32'h0);
    chk("outside", rv, 32'h0);
    io(1'b0, plfb_pkg::OFS_RX_BYTE, 4'h1, 32'h0);
    chk("rx_kept", rv[7:0], pop(1));
    stall = 1'b1;
    io(1'b0, plfb_pkg::OFS_TX_LVL, 4'h3, 32'h0);
    chk("tx_level", rv[15:0], 32'h8);
    for (i = 0; i < 4; i++) begin
      lf = nx(lf);
      w = {lf, w[31:8]};
    end
    put(plfb_pkg::OFS_TX_WIDE, 4'hf, w);
    put(plfb_pkg::OFS_TX_BYTE, 4'h2, {16'h0, nx(lf), 8'h0});
    put(plfb_pkg::OFS_TX_WIDE, 4'h3, ~w);
    io(1'b0, plfb_pkg::OFS_TX_LVL, 4'h3, 32'h0);
    chk("tx_level", rv[15:0], 32'h1);
    io(1'b0, plfb_pkg::OFS_TX_STAT, 4'h8, 32'h0);
    chk("tx_status", rv[24], 32'h1);
    put(plfb_pkg::OFS_TX_BYTE, 4'h2, {16'h0, w[7:0], 8'h0});
    io(1'b0, plfb_pkg::OFS_TX_STAT, 4'h8, 32'h0);
    chk("tx_status", rv[24], 32'h0);
    io(1'b0, plfb_pkg::OFS_TX_LVL, 4'h3, 32'h0);
    chk("tx_level", rv[15:0], 32'h0);
    stall = 1'b0;
    for (i = 0; i < 60 && lm_u.gotq.size() < 8; i++) @(negedge clk);
    chk("tx_count", lm_u.gotq.size(), 32'h8);
    for (i = 0; i < 8; i++) chk("tx_byte", lm_u.gotq[i], tq[i]);
    stall = 1'b1;
    rx_send(2);
    put(plfb_pkg::OFS_TX_BYTE, 4'h2, 32'h0000_a500);
    io(1'b1, plfb_pkg::OFS_SLOT_RST, 4'h1, 32'h1);
    chk("link_rst", link_rst, 32'h1);
    chk("slot_rst", first_slot.reset, 32'h1);
    io(1'b0, plfb_pkg::OFS_RX_LVL, 4'h3, 32'h0);
    chk("rx_flush", rv[15:0], 32'h0);
    io(1'b0, plfb_pkg::OFS_TX_LVL, 4'h3, 32'h0);
    chk("tx_flush", rv[15:0], 32'h8);
    first_slot_error = 1'b1;
    repeat (4) @(negedge clk);
    io(1'b0, plfb_pkg::OFS_SLOT_RST, 4'h1, 32'h0);
    chk("slot_err", rv[0], 32'h1);
    io(1'b1, plfb_pkg::OFS_SLOT_RST, 4'h1, 32'h0);
    chk("link_rst", link_rst, 32'h0);
    io(1'b1, plfb_pkg::OFS_SLOT_HLT, 4'h2, 32'h100);
    chk("halt", first_slot.halt, 32'h1);
    io(1'b1, plfb_pkg::OFS_SLOT_HLT, 4'h2, 32'h0);
    chk("halt", first_slot.halt, 32'h0);
    up_ctl = 2'h3;
    sub_ctl = 2'h2;
    {link_rate_switch, first_slot_control_switch, slave_slots_control_switch} = 3'h7;
    repeat (5) @(negedge clk);
    chk("rate", link_rate_mhz, plfb_pkg::RATE_SLOW_MHZ);
    chk("up_slot", first_slot, up_ctl);
    chk("up_err", up_error, 32'h1);
    chk("slaves", slave_slots, up_ctl);
    slave_slots_control_switch = 1'b0;
    repeat (5) @(negedge clk);
    chk("slaves", slave_slots, sub_ctl);
    first_slot_control_switch = 1'b0;
    repeat (5) @(negedge clk);
    chk("host_slot", first_slot, 32'h0);
    chk("up_err", up_error, 32'h0);
    give_verdict();
  end
endmodule // pci_link_fifo_bridge_tb
